/* File: lcc_pkg.sv */
`default_nettype none
package lcc_pkg;
  // clock and caption bit timing
  localparam int CLK_NS = 20;
  localparam int BIT_NS = 1986;
  localparam int BIT_CYC = BIT_NS / CLK_NS;
  localparam int LEAD_NS = 10500;
  localparam int LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RUNIN_CYCLES = 7;
  localparam logic [11:0] BIT_LAST = 12'(BIT_CYC - 1);
  localparam logic [11:0] LEAD_LAST = 12'(LEAD_CYC - 1);
  localparam logic [11:0] RUNIN_SAMP_LAST =
    12'(RUNIN_CYCLES * BIT_CYC - 1);
  localparam logic [4:0] RUNIN_LAST = 5'(RUNIN_CYCLES - 1);
  localparam logic [4:0] GAP_LAST = 5'h01;
  localparam logic [4:0] START_LAST = 5'h00;
  localparam logic [4:0] DATA_LAST = 5'h0F;
  localparam logic [15:0] PHASE_STEP = 16'(65536 / BIT_CYC);
  // caption lines
  localparam logic [9:0] ODD_CAP_LINE = 10'h015;
  localparam logic [9:0] EVEN_CAP_LINE = 10'h11C;
  // caption byte subaddresses and reset value
  localparam logic [4:0] EXT0_OFS = 5'h08;
  localparam logic [4:0] EXT1_OFS = 5'h09;
  localparam logic [4:0] ODD0_OFS = 5'h0A;
  localparam logic [4:0] ODD1_OFS = 5'h0B;
  localparam logic [2:0] CAP_BLOCK = 3'h2;
  localparam logic [7:0] CAP_RST = 8'h00;
  // sample levels
  localparam logic [7:0] BLANK_LVL = 8'h10;
  localparam logic [7:0] HIGH_LVL = 8'h7E;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_LEAD = 3'b001,
    S_RUNIN = 3'b010,
    S_GAP = 3'b011,
    S_START = 3'b100,
    S_DATA = 3'b101,
    S_TAIL = 3'b110
  } lcc_state_type;
endpackage
`default_nettype wire

/* File: lcc_caption_inserter.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RULE_01 - insert only on line 21 odd, 284 even
// RULE_02 - seven-cycle run-in locked to bit rate
// RULE_03 - two blank bit periods, then start one
// RULE_04 - sixteen bits: two bytes, odd parity each
// RULE_05 - odd field uses odd caption bytes
// RULE_06 - even line 284 uses extended bytes
// RULE_07 - all caption timing generated internally
// RULE_08 - pixel input discarded on caption lines
// RULE_09 - single-buffered bytes, no extra frame delay
// RULE_10 - host writes bytes by preceding line
// RULE_11 - host writes zeros when nothing new
// RULE_12 - host keeps control codes field aligned
// RULE_13 - vsync interrupts host to reload bytes
// RULE_14 - odd bytes at subaddresses 0A, 0B
// RULE_15 - extended bytes at subaddresses 08, 09
// RULE_16 - bits sent lsb first, parity last
module lcc_caption_inserter
  import lcc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic line_start_i,
  input wire logic [9:0] line_num_i,
  input wire logic line_odd_i,
  input wire logic pix_valid_i,
  input wire logic [7:0] pix_data_i,
  output logic pix_ready_o,
  output logic out_valid_o,
  output logic [7:0] out_data_o,
  input wire logic out_ready_i,
  input wire logic host_wr_i,
  input wire logic [4:0] host_addr_i,
  input wire logic [7:0] host_wdata_i,
  output logic [7:0] host_rdata_o
);

  lcc_state_type state_ff, nxt_state;
  logic [11:0] cnt_ff, nxt_cnt;
  logic [4:0] bitn_ff, nxt_bitn;
  logic [15:0] phase_ff;
  logic [15:0] sh_ff;
  logic cap_ff;
  logic [7:0] cap_byte_ff [4];
  logic [7:0] fifo_mem_ff [2];
  logic wr_ptr_ff, rd_ptr_ff;
  logic [1:0] fcnt_ff;
  logic [11:0] run_samp_ff;

  logic is_cap, reg_hit, gen_valid, adv, bit_end;
  logic in_rdy, push, pop;
  logic [7:0] push_data, gen_sample, sine_val, byte0, byte1;
  logic [4:0] phase_last;
  lcc_state_type phase_next;
  logic [15:0] load_word;

  // caption line decode
  assign is_cap = (line_odd_i && line_num_i == ODD_CAP_LINE) ||
    (!line_odd_i && line_num_i == EVEN_CAP_LINE); // see RULE_01

  // host byte registers, one byte deep each
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_reg
    logic wr_hit;
    assign wr_hit = host_wr_i && (host_addr_i == EXT0_OFS + 5'(gi));
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        cap_byte_ff[gi] <= CAP_RST;
      end else if (wr_hit) begin
        cap_byte_ff[gi] <= host_wdata_i; // see RULE_14 see RULE_15
      end
    end
  end

  assign reg_hit = host_addr_i[4:2] == CAP_BLOCK;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_rdata_o <= 8'h00;
    end else begin
      host_rdata_o <= reg_hit ? cap_byte_ff[host_addr_i[1:0]] : 8'h00;
    end
  end

  // field picks the byte pair: odd 0A/0B, even 08/09
  assign byte0 = cap_byte_ff[{line_odd_i, 1'b0}]; // see RULE_05 see RULE_06
  assign byte1 = cap_byte_ff[{line_odd_i, 1'b1}];
  // bit 7 of each byte is replaced by generated odd parity
  assign load_word = {~^byte1[6:0], byte1[6:0],
    ~^byte0[6:0], byte0[6:0]}; // see RULE_04

  // generator paces itself on accepted samples so a stall loses none
  assign gen_valid = state_ff != S_IDLE;
  assign adv = cap_ff && gen_valid && in_rdy;
  assign bit_end = cnt_ff == BIT_LAST;

  assign phase_last = (state_ff == S_RUNIN) ? RUNIN_LAST :
    (state_ff == S_GAP) ? GAP_LAST :
    (state_ff == S_START) ? START_LAST : DATA_LAST;
  assign phase_next = (state_ff == S_RUNIN) ? S_GAP :
    (state_ff == S_GAP) ? S_START :
    (state_ff == S_START) ? S_DATA : S_TAIL;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_bitn = bitn_ff;
    if (line_start_i) begin
      nxt_state = is_cap ? S_LEAD : S_IDLE;
      nxt_cnt = 12'h000;
      nxt_bitn = 5'h00;
    end else if (adv) begin
      nxt_cnt = cnt_ff + 12'h001; // see RULE_07
      case (state_ff)
        S_LEAD: begin
          if (cnt_ff == LEAD_LAST) begin
            nxt_state = S_RUNIN;
            nxt_cnt = 12'h000;
          end
        end
        S_RUNIN, S_GAP, S_START, S_DATA: begin
          if (bit_end) begin
            nxt_cnt = 12'h000;
            nxt_bitn = bitn_ff + 5'h01;
            if (bitn_ff == phase_last) begin
              nxt_state = phase_next; // see RULE_03
              nxt_bitn = 5'h00;
            end
          end
        end
        S_TAIL: begin
          nxt_cnt = cnt_ff;
        end
        default: begin
          nxt_state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 12'h000;
      bitn_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      bitn_ff <= nxt_bitn;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_ff <= 1'b0;
    end else if (line_start_i) begin
      cap_ff <= is_cap; // see RULE_08
    end
  end

  // bytes are taken at the caption line start, no second buffer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_ff <= 16'h0000;
    end else if (line_start_i && is_cap) begin
      sh_ff <= load_word; // see RULE_09
    end else if (adv && state_ff == S_DATA && bit_end) begin
      sh_ff <= {1'b0, sh_ff[15:1]}; // see RULE_16
    end
  end

  // phase restarts every bit, keeping run-in locked to data
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_ff <= 16'h0000;
    end else if (state_ff != S_RUNIN || line_start_i) begin
      phase_ff <= 16'h0000;
    end else if (adv) begin
      phase_ff <= bit_end ? 16'h0000 : phase_ff + PHASE_STEP; // see RULE_02
    end
  end

  // one sine period, trough at blanking level
  always_comb begin
    case (phase_ff[15:12])
      4'h0: sine_val = 8'h47;
      4'h1: sine_val = 8'h5C;
      4'h2: sine_val = 8'h6E;
      4'h3: sine_val = 8'h7A;
      4'h4: sine_val = 8'h7E;
      4'h5: sine_val = 8'h7A;
      4'h6: sine_val = 8'h6E;
      4'h7: sine_val = 8'h5C;
      4'h8: sine_val = 8'h47;
      4'h9: sine_val = 8'h32;
      4'hA: sine_val = 8'h20;
      4'hB: sine_val = 8'h14;
      4'hC: sine_val = 8'h10;
      4'hD: sine_val = 8'h14;
      4'hE: sine_val = 8'h20;
      default: sine_val = 8'h32;
    endcase
  end

  assign gen_sample = (state_ff == S_RUNIN) ? sine_val :
    (state_ff == S_START) ? HIGH_LVL :
    (state_ff == S_DATA && sh_ff[0]) ? HIGH_LVL : BLANK_LVL;

  // pixels are swallowed on caption lines, the generator owns the slot
  assign pix_ready_o = cap_ff ? 1'b1 : in_rdy; // see RULE_08
  assign push = cap_ff ? adv : (pix_valid_i && in_rdy);
  assign push_data = cap_ff ? gen_sample : pix_data_i;

  // two-entry output buffer
  assign in_rdy = fcnt_ff != 2'h2;
  assign out_valid_o = fcnt_ff != 2'h0;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = fifo_mem_ff[rd_ptr_ff];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_mem_ff[0] <= 8'h00;
      fifo_mem_ff[1] <= 8'h00;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      fcnt_ff <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem_ff[wr_ptr_ff] <= push_data;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      fcnt_ff <= fcnt_ff + 2'(push) - 2'(pop);
    end
  end

  // helper: accepted run-in samples
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run_samp_ff <= 12'h000;
    end else if (state_ff != S_RUNIN || line_start_i) begin
      run_samp_ff <= 12'h000;
    end else if (adv) begin
      run_samp_ff <= run_samp_ff + 12'h001;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  only_cap_line_a: assert property ( // see RULE_01
    gen_valid |-> cap_ff)
    else $error("caption generator active off a caption line");

  runin_len_a: assert property ( // see RULE_02
    (state_ff == S_RUNIN && nxt_state == S_GAP && !line_start_i)
      |-> run_samp_ff == RUNIN_SAMP_LAST)
    else $error("run-in length is not seven bit periods");

  gap_start_a: assert property ( // see RULE_03
    (state_ff == S_GAP |-> gen_sample == BLANK_LVL) and
    (state_ff == S_START |-> gen_sample == HIGH_LVL))
    else $error("gap or start bit level wrong");

  parity_load_a: assert property ( // see RULE_04
    (line_start_i && is_cap) |=> (^sh_ff[7:0]) && (^sh_ff[15:8]))
    else $error("loaded caption byte lacks odd parity");

  data_end_a: assert property ( // see RULE_04
    (state_ff == S_DATA && adv && bit_end && bitn_ff == DATA_LAST &&
      !line_start_i) |=> state_ff == S_TAIL)
    else $error("data phase did not end after sixteen bits");

  odd_bytes_a: assert property ( // see RULE_05
    (line_start_i && is_cap && line_odd_i) |=>
      sh_ff[6:0] == $past(cap_byte_ff[2][6:0]) &&
      sh_ff[14:8] == $past(cap_byte_ff[3][6:0]))
    else $error("odd field did not load odd caption bytes");

  even_bytes_a: assert property ( // see RULE_06
    (line_start_i && is_cap && !line_odd_i) |=>
      sh_ff[6:0] == $past(cap_byte_ff[0][6:0]) &&
      sh_ff[14:8] == $past(cap_byte_ff[1][6:0]))
    else $error("even field did not load extended bytes");

  pix_drop_a: assert property ( // see RULE_08
    cap_ff |-> pix_ready_o && push_data == gen_sample)
    else $error("pixel data reached output on caption line");

  lsb_first_a: assert property ( // see RULE_16
    (state_ff == S_DATA && adv && bit_end && !line_start_i) |=>
      sh_ff == {1'b0, $past(sh_ff[15:1])})
    else $error("caption bits not shifted lsb first");

  odd_reg_a: assert property ( // see RULE_14
    (host_wr_i && host_addr_i == ODD0_OFS) |=>
      cap_byte_ff[2] == $past(host_wdata_i))
    else $error("odd caption byte not stored");

  ext_reg_a: assert property ( // see RULE_15
    (host_wr_i && host_addr_i == EXT1_OFS) |=>
      cap_byte_ff[1] == $past(host_wdata_i))
    else $error("extended caption byte not stored");

  fifo_bound_a: assert property (
    fcnt_ff <= 2'h2 && !(push && !in_rdy))
    else $error("output buffer overflow");

endmodule
`default_nettype wire

/* File: lcc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lcc_host_model (
  input wire logic ref_clk_i,
  input wire logic load_i,
  input wire logic [31:0] bytes_i,
  input wire logic [4:0] peek_i,
  output logic wr_o,
  output logic [4:0] addr_o,
  output logic [7:0] wdata_o,
  output logic busy_o
);
  logic [2:0] step_ff = 3'h0;
  // one burst writes all four bytes, so a code pair never splits
  assign busy_o = step_ff != 3'h0;
  assign wr_o = busy_o;
  assign addr_o = busy_o ? 5'h07 + 5'(step_ff) : peek_i;
  // an idle field is loaded by the caller as zero bytes
  assign wdata_o = bytes_i[8 * 2'(step_ff - 3'h1) +: 8];
  always_ff @(posedge ref_clk_i) begin
    if (load_i || (busy_o && step_ff != 3'h4)) begin
      step_ff <= step_ff + 3'h1;
    end else begin
      step_ff <= 3'h0;
    end
  end
endmodule
`default_nettype wire

/* File: test_line21_caption_inserter.sv */
`timescale 1ns/1ps
`default_nettype none
module test_line21_caption_inserter;
  import lcc_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic line_start_i = 1'b0;
  logic [9:0] line_num_i = 10'h000;
  logic line_odd_i = 1'b0;
  logic pix_valid_i = 1'b0;
  logic [7:0] pix_data_i = 8'h00;
  logic out_ready_i = 1'b0;
  logic load = 1'b0;
  logic [31:0] bytes = 32'h0;
  logic [4:0] peek = 5'h00;
  logic host_wr, busy, pix_ready_o, out_valid_o;
  logic [4:0] host_addr;
  logic [7:0] host_wdata, out_data_o, host_rdata_o;
  int n_errors = 0;
  int n_tests = 0;
  bit stall = 0;
  lcc_caption_inserter u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .line_start_i(line_start_i), .line_num_i(line_num_i),
    .line_odd_i(line_odd_i), .pix_valid_i(pix_valid_i),
    .pix_data_i(pix_data_i), .pix_ready_o(pix_ready_o),
    .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_ready_i(out_ready_i), .host_wr_i(host_wr),
    .host_addr_i(host_addr), .host_wdata_i(host_wdata),
    .host_rdata_o(host_rdata_o));
  lcc_host_model u_host (.ref_clk_i(ref_clk_i), .load_i(load),
    .bytes_i(bytes), .peek_i(peek), .wr_o(host_wr), .addr_o(host_addr),
    .wdata_o(host_wdata), .busy_o(busy));
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic load_bytes(input logic [31:0] b);
    bytes = b;
    load = 1'b1;
    tick(1);
    load = 1'b0;
    while (busy) begin
      tick(1);
    end
    tick(1);
  endtask
  task automatic start_line(input logic [9:0] num, input logic odd);
    line_num_i = num;
    line_odd_i = odd;
    line_start_i = 1'b1;
    tick(1);
    line_start_i = 1'b0;
  endtask
  // pop one sample; a stall holds ready low for two cycles first
  task automatic pop(output logic [7:0] s);
    int w;
    w = 0;
    if (stall) begin
      out_ready_i = 1'b0;
      tick(2);
    end
    out_ready_i = 1'b1;
    while (out_valid_o !== 1'b1 && w < 50) begin
      tick(1);
      w++;
    end
    s = (w < 50) ? out_data_o : 8'hXX;
    tick(1);
  endtask
  // expected level of sample i of a caption line, -1 inside run-in
  function automatic int lvl(input int i, input logic [15:0] b);
    int k;
    k = i - LEAD_CYC - (RUNIN_CYCLES + 2) * BIT_CYC;
    if (i < LEAD_CYC) return BLANK_LVL;
    if (k < -2 * BIT_CYC) return -1;
    if (k < BIT_CYC) return (k < 0) ? BLANK_LVL : HIGH_LVL;
    k = k / BIT_CYC - 1;
    if (k > 15) return BLANK_LVL;
    if (k % 8 == 7) return (^b[k - 7 +: 7]) ? BLANK_LVL : HIGH_LVL;
    return b[k] ? HIGH_LVL : BLANK_LVL;
  endfunction
  task automatic t_regs();
    logic [7:0] exp_b;
    for (int i = 0; i < 6; i++) begin
      peek = 5'h07 + 5'(i);
      tick(2);
      check(host_rdata_o, 8'h00);
    end
    load_bytes(32'hB1A2_9384);
    for (int i = 0; i < 6; i++) begin
      peek = 5'h07 + 5'(i);
      tick(2);
      exp_b = (i % 5 == 0) ? 8'h00 : bytes[8 * i - 8 +: 8];
      check(host_rdata_o, exp_b);
    end
  endtask
  task automatic t_pix();
    logic [7:0] s;
    out_ready_i = 1'b0;
    start_line(10'h016, 1'b1);
    pix_valid_i = 1'b1;
    pix_data_i = 8'h11;
    tick(1);
    pix_data_i = 8'h22;
    tick(1);
    check(8'(pix_ready_o), 8'h00);
    pix_valid_i = 1'b0;
    pop(s);
    check(s, 8'h11);
    pop(s);
    check(s, 8'h22);
    start_line(10'h015, 1'b0);
    pix_valid_i = 1'b1;
    pix_data_i = 8'h5A;
    tick(1);
    pix_valid_i = 1'b0;
    pop(s);
    check(s, 8'h5A);
  endtask
  task automatic caption(input logic [9:0] n, input logic o,
    input logic [15:0] b);
    logic [7:0] s, hi, lo;
    int e, j;
    // the line before drains tail samples of an earlier caption line
    start_line(n - 10'h001, o);
    tick(2);
    start_line(n, o);
    pix_valid_i = 1'b1;
    pix_data_i = 8'hFF;
    check(8'(pix_ready_o), 8'h01);
    hi = 8'h00;
    lo = 8'hFF;
    for (int i = 0; i < 3120; i++) begin
      pop(s);
      e = lvl(i, b);
      if (e < 0) begin
        check(8'(s >= BLANK_LVL && s <= HIGH_LVL), 8'h01);
        // every bit period of run-in must swing through a full cycle
        j = (i - LEAD_CYC) % BIT_CYC;
        hi = (j == 0 || s > hi) ? s : hi;
        lo = (j == 0 || s < lo) ? s : lo;
        if (j == BIT_CYC - 1) begin
          check(hi, HIGH_LVL);
          check(lo, BLANK_LVL);
        end
      end else begin
        check(s, 8'(e));
      end
    end
    pix_valid_i = 1'b0;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    #1;
    check(8'(pix_ready_o), 8'h01);
    check(8'(out_valid_o), 8'h00);
    rst_i = 1'b0;
    t_regs();
    t_pix();
    load_bytes(32'h2C14_C5E3);
    caption(10'h015, 1'b1, 16'h2C14);
    stall = 1;
    caption(10'h11C, 1'b0, 16'hC5E3);
    stall = 0;
    load_bytes(32'h0);
    caption(10'h015, 1'b1, 16'h0000);
    end_of_test();
  end
  initial begin
    #1000000;
    n_errors++;
    end_of_test();
  end
endmodule
`default_nettype wire
